// >>> design/pmc_pkg.sv
// Package of constants for the microphone port control block
package pmc_pkg;
	localparam logic [7:0] PMC_ADDR_PORT_A  = 8'hF0;
	localparam logic [7:0] PMC_ADDR_PORT_B  = 8'hF1;
	localparam logic [7:0] PMC_CTRL_RESET   = 8'h00;
	localparam logic [7:0] PMC_CTRL_MASK    = 8'hC7;
	localparam int         PMC_BIT_R_EN     = 7;
	localparam int         PMC_BIT_L_EN     = 6;
	localparam int         PMC_BIT_RATE     = 2;
	localparam int         PMC_BIT_PHASE    = 1;
	localparam int         PMC_BIT_SEL      = 0;
	localparam logic [2:0] PMC_DIV_FAST     = 3'h3;
	localparam logic [2:0] PMC_DIV_SLOW     = 3'h7;
	localparam logic [2:0] PMC_SYNC_LAG     = 3'h3;
	localparam int         PMC_FIFO_DEPTH   = 16;
	localparam int         PMC_FIFO_WIDTH   = 5;
endpackage : pmc_pkg

// >>> design/pmc_stream_if.sv
// Valid/ready stream carrier between the port logic and the FIFO
`timescale 1ns/1ns
`default_nettype none
interface pmc_stream_if #(parameter int W = 5);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : pmc_stream_if
`default_nettype wire

// >>> design/pmc_fifo.sv
// Parameterised FIFO with registered read data
`timescale 1ns/1ns
`default_nettype none
module pmc_fifo #(
	parameter int W = 5,
	parameter int D = 16
) (
	input  wire logic clk,
	input  wire logic nrst,
	pmc_stream_if.snk in_s,
	input  wire logic out_ready,
	output logic      out_valid,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0]  wp_r;
	logic [AW:0]  rp_r;
	logic         full;
	logic         empty;
	logic         push;
	logic         pop;

	assign full  = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
	assign empty = (wp_r == rp_r);
	assign in_s.ready = !full;
	assign push = in_s.valid && !full;
	assign pop  = !empty && (!out_valid || out_ready);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r[AW-1:0]] <= in_s.data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (push) begin
				wp_r <= wp_r + {{AW{1'b0}}, 1'b1};
			end
			if (pop) begin
				rp_r <= rp_r + {{AW{1'b0}}, 1'b1};
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data  <= mem[rp_r[AW-1:0]];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end
endmodule : pmc_fifo
`default_nettype wire

// >>> design/pmc_mic_ctrl.sv
// Two-port digital microphone control with register port and sample FIFO
//
// Notes on behaviour
// RL1 - Right channel of a port is captured only while control bit 7 is set.
// RL2 - Left channel of a port is captured only while control bit 6 is set.
// RL3 - Rate bit 2 clear: port clock is system clock divided by four.
// RL4 - Rate bit 2 set: port clock is system clock divided by eight.
// RL5 - Phase bit 1: clear samples at clock edges, set samples midway between. At divide by four both settings sample at the same points.
// RL6 - Select bit 0 clear: rising-edge data left, falling-edge data right.
// RL7 - Select bit 0 set: rising-edge data right, falling-edge data left.
// RL8 - Two identical port control registers at offsets F0 and F1.
// RL9 - All control fields reset to zero.
// RL10 - Port clock runs only while a channel is enabled, else held low.
// RL11 - Microphones drive data only in their own clock phase, release otherwise.
`timescale 1ns/1ns
`default_nettype none
module pmc_mic_ctrl
	import pmc_pkg::*;
#(
	parameter int FIFO_DEPTH = PMC_FIFO_DEPTH
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic      [1:0] mic_bit_clock,
	input  wire logic [1:0] mic_data,
	output logic            smp_valid,
	output logic      [4:0] smp_data,
	input  wire logic       smp_ready
);
	////////////////////////////////////////////////////////////////////////
	// Control registers
	logic [7:0] ctrl_r [2];
	logic [1:0] port_right_enable;
	logic [1:0] port_left_enable;
	logic [1:0] port_sample_phase;
	logic [1:0] port_rate;
	logic [1:0] port_sel;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r[0] <= PMC_CTRL_RESET; // RL9
			ctrl_r[1] <= PMC_CTRL_RESET; // RL9
		end else if (reg_wr) begin
			if (reg_addr == PMC_ADDR_PORT_A) begin
				ctrl_r[0] <= reg_wdata & PMC_CTRL_MASK; // RL8
			end
			if (reg_addr == PMC_ADDR_PORT_B) begin
				ctrl_r[1] <= reg_wdata & PMC_CTRL_MASK; // RL8
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == PMC_ADDR_PORT_A) begin
				reg_rdata <= ctrl_r[0];
			end else if (reg_addr == PMC_ADDR_PORT_B) begin
				reg_rdata <= ctrl_r[1];
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-port clock generation and capture
	logic [3:0] cand_valid;
	logic [4:0] cand_data [4];

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_port
			logic [2:0] div_r;
			logic [2:0] sync_r;
			logic       din_r;
			logic       rise_bit_r;
			logic       fall_bit_r;
			logic       rise_new_r;
			logic       fall_new_r;
			logic       active;
			logic [2:0] top;
			logic [2:0] half;
			logic [2:0] quarter;
			logic [2:0] rise_pt;
			logic [2:0] fall_pt;
			logic       cap_rise;
			logic       cap_fall;

			assign port_right_enable[p] = ctrl_r[p][PMC_BIT_R_EN];
			assign port_left_enable[p]  = ctrl_r[p][PMC_BIT_L_EN];
			assign port_rate[p]         = ctrl_r[p][PMC_BIT_RATE];
			assign port_sample_phase[p] = ctrl_r[p][PMC_BIT_PHASE];
			assign port_sel[p]          = ctrl_r[p][PMC_BIT_SEL];
			assign active = port_right_enable[p] | port_left_enable[p]; // RL10
			assign top    = port_rate[p] ? PMC_DIV_SLOW : PMC_DIV_FAST; // RL3 RL4
			assign half   = top >> 1;
			assign quarter = top >> 2;

			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					div_r <= 3'h0;
				end else if (!active || div_r >= top) begin
					div_r <= 3'h0; // RL3 RL4
				end else begin
					div_r <= div_r + 3'h1;
				end
			end

			// Clock high for first half of the period, low otherwise
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					mic_bit_clock[p] <= 1'b0;
				end else if (!active) begin
					mic_bit_clock[p] <= 1'b0; // RL10
				end else begin
					mic_bit_clock[p] <= (div_r >= top || div_r < half);
				end
			end

			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					sync_r <= 3'h0;
				end else begin
					sync_r <= {sync_r[1:0], mic_data[p]};
				end
			end

			// Pin-side sample points: last cycle of a phase, or its middle
			// Divide by four leaves one settled cycle, so both phases meet there
			assign rise_pt  = port_sample_phase[p] ? quarter + 3'h1 : half; // RL5
			assign fall_pt  = port_sample_phase[p] ? half + quarter + 3'h2 : top; // RL5
			// Shifted by the synchroniser depth, wrapped to the period
			assign cap_rise = active && (div_r == ((rise_pt + PMC_SYNC_LAG) & top)); // RL5
			assign cap_fall = active && (div_r == ((fall_pt + PMC_SYNC_LAG) & top)); // RL5

			// Pin change counts once second and third stages agree
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					din_r <= 1'b0;
				end else if (sync_r[1] == sync_r[2]) begin
					din_r <= sync_r[1];
				end
			end

			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					rise_bit_r <= 1'b0;
					fall_bit_r <= 1'b0;
					rise_new_r <= 1'b0;
					fall_new_r <= 1'b0;
				end else begin
					rise_new_r <= cap_rise;
					fall_new_r <= cap_fall;
					if (cap_rise) begin
						rise_bit_r <= din_r;
					end
					if (cap_fall) begin
						fall_bit_r <= din_r;
					end
				end
			end

			// Candidates: {port, right, bit}; index 2p left, 2p+1 right
			assign cand_valid[2*p] = rise_new_r && !port_sel[p] && port_left_enable[p] // RL2 RL6
				|| fall_new_r && port_sel[p] && port_left_enable[p]; // RL7
			assign cand_valid[2*p+1] = fall_new_r && !port_sel[p] && port_right_enable[p] // RL1 RL6
				|| rise_new_r && port_sel[p] && port_right_enable[p]; // RL7
			assign cand_data[2*p]   = {2'(p), 1'b0, 1'b0, port_sel[p] ? fall_bit_r : rise_bit_r}; // RL6 RL7
			assign cand_data[2*p+1] = {2'(p), 1'b1, 1'b0, port_sel[p] ? rise_bit_r : fall_bit_r}; // RL6 RL7
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Arbitration of captured bits into the FIFO, one per cycle
	pmc_stream_if #(.W(PMC_FIFO_WIDTH)) push_s ();
	logic       pend_v_r;
	logic [4:0] pend_d_r;
	logic       sel_v;
	logic [4:0] sel_d;

	always_comb begin
		sel_v = 1'b0;
		sel_d = 5'h00;
		for (int i = 3; i >= 0; i--) begin
			if (cand_valid[i]) begin
				sel_v = 1'b1;
				sel_d = cand_data[i];
			end
		end
	end

	// Capture points of the four channels never coincide at the same port;
	// both ports may collide, and then the lowest candidate index wins and the others are dropped.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pend_v_r  <= 1'b0;
			pend_d_r  <= 5'h00;
		end else begin
			if (sel_v) begin
				pend_v_r <= 1'b1;
				pend_d_r <= sel_d;
			end else if (push_s.ready) begin
				pend_v_r <= 1'b0;
			end
		end
	end

	assign push_s.valid = pend_v_r;
	assign push_s.data  = pend_d_r;

	pmc_fifo #(.W(PMC_FIFO_WIDTH), .D(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.in_s      (push_s),
		.out_ready (smp_ready),
		.out_valid (smp_valid),
		.out_data  (smp_data)
	);
endmodule : pmc_mic_ctrl
`default_nettype wire

// >>> dv/pmc_mic_ctrl_chk.sv
// Port-level checker for the microphone port control block
`timescale 1ns/1ns
`default_nettype none
module pmc_mic_ctrl_chk
	import pmc_pkg::*;
(
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] mic_bit_clock,
	input wire logic       smp_valid,
	input wire logic [4:0] smp_data
);
	logic [7:0] sh_r [2];
	logic [5:0] quiet_r;
	// Shadow of both control registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) sh_r <= '{8'h00, 8'h00};
		else if (reg_wr && reg_addr[7:1] == 7'h78) sh_r[reg_addr[0]] <= reg_wdata & PMC_CTRL_MASK;
	end
	// Cycles since the last write, saturating
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) quiet_r <= 6'h00;
		else if (reg_wr) quiet_r <= 6'h00;
		else if (quiet_r != 6'h3F) quiet_r <= quiet_r + 6'h01;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////
	AST_RESET_VAL: assert property ($rose(nrst) |-> reg_rdata == 8'h00
		&& mic_bit_clock == 2'b00 && !smp_valid) else $error("outputs not idle after reset");
	AST_READ_A: assert property (reg_rd && !reg_wr && reg_addr == PMC_ADDR_PORT_A
		|=> reg_rdata == sh_r[0]) else $error("port A control readback wrong");
	AST_READ_B: assert property (reg_rd && !reg_wr && reg_addr == PMC_ADDR_PORT_B
		|=> reg_rdata == sh_r[1]) else $error("port B control readback wrong");
	AST_READ_UNMAP: assert property (reg_rd && reg_addr[7:1] != 7'h78
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	AST_IDLE_LOW: assert property (sh_r[0][7:6] == 2'b00 && quiet_r > 6'h04
		|-> !mic_bit_clock[0]) else $error("disabled port clock not low");
	AST_DIV4: assert property (disable iff (!nrst || quiet_r < 6'h04)
		quiet_r[5] && |sh_r[0][7:6] && !sh_r[0][2] && $rose(mic_bit_clock[0])
		|=> !$rose(mic_bit_clock[0]) [*3] ##1 $rose(mic_bit_clock[0]))
		else $error("port clock period not four");
	AST_DIV8: assert property (disable iff (!nrst || quiet_r < 6'h04)
		quiet_r[5] && |sh_r[1][7:6] && sh_r[1][2] && $rose(mic_bit_clock[1])
		|=> !$rose(mic_bit_clock[1]) [*7] ##1 $rose(mic_bit_clock[1]))
		else $error("port clock period not eight");
	AST_RIGHT_GATE: assert property (smp_valid && quiet_r[5] && smp_data[2]
		|-> sh_r[smp_data[3]][7]) else $error("right sample from disabled channel");
	AST_LEFT_GATE: assert property (smp_valid && quiet_r[5] && !smp_data[2]
		|-> sh_r[smp_data[3]][6]) else $error("left sample from disabled channel");
endmodule : pmc_mic_ctrl_chk
bind pmc_mic_ctrl pmc_mic_ctrl_chk chk_u (.clk(clk), .nrst(nrst), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.mic_bit_clock(mic_bit_clock), .smp_valid(smp_valid), .smp_data(smp_data));
`default_nettype wire

// >>> dv/pmc_mic_model.sv
// Two microphone pairs sharing each port's clock and data pin
`timescale 1ns/1ns
`default_nettype none
module pmc_mic_model (
	input  wire logic       clk,
	input  wire logic [1:0] mic_bit_clock,
	input  wire logic [1:0] rise_bit,
	input  wire logic [1:0] fall_bit,
	output logic      [1:0] mic_data
);
	logic [3:0] low_r [2] = '{4'hF, 4'hF};
	logic [1:0] junk_r    = 2'b01;
	always_ff @(posedge clk) begin
		for (int p = 0; p < 2; p++) begin
			low_r[p] <= mic_bit_clock[p] ? 4'h0 : (low_r[p] == 4'hF ? 4'hF : low_r[p] + 4'h1);
		end
		junk_r <= ~junk_r;
	end
	// Released pin toggles so stale data cannot pass
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			if (mic_bit_clock[p]) mic_data[p] = rise_bit[p];
			else if (low_r[p] < 4'h6) mic_data[p] = fall_bit[p];
			else mic_data[p] = junk_r[p];
		end
	end
endmodule : pmc_mic_model
`default_nettype wire

// >>> dv/pmc_mic_ctrl_bench.sv
// Self-checking bench for the microphone port control block
`timescale 1ns/1ns
`default_nettype none
module pmc_mic_ctrl_bench import pmc_pkg::*;;
	logic       clk = 1'b0;
	logic       nrst = 1'b0;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [1:0] mic_bit_clock;
	logic [1:0] mic_data;
	logic       smp_valid;
	logic [4:0] smp_data;
	logic       smp_ready = 1'b0;
	logic [1:0] rise_bit = 2'b00;
	logic [1:0] fall_bit = 2'b00;
	logic [7:0] cfg;
	int         mismatches = 0;
	int         checked = 0;
	int         n;
	int         got = 0;
	pmc_mic_ctrl #(.FIFO_DEPTH(PMC_FIFO_DEPTH)) dut_u (.clk(clk), .nrst(nrst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.mic_bit_clock(mic_bit_clock), .mic_data(mic_data), .smp_valid(smp_valid),
		.smp_data(smp_data), .smp_ready(smp_ready));
	pmc_mic_model mic_u (.clk(clk), .mic_bit_clock(mic_bit_clock), .rise_bit(rise_bit),
		.fall_bit(fall_bit), .mic_data(mic_data));
	initial forever #5 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		check(reg_rdata, e);
	endtask : rd
	task automatic count_rises(input logic p, output int r);
		logic prev;
		r = 0;
		prev = mic_bit_clock[p];
		repeat (32) begin
			@(negedge clk);
			r += int'(mic_bit_clock[p] && !prev);
			prev = mic_bit_clock[p];
		end
	endtask : count_rises
	function automatic logic exp_bit(input logic [7:0] c, input logic right, input logic p);
		return (right ^ c[0]) ? fall_bit[p] : rise_bit[p];
	endfunction : exp_bit
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hA85CDEA2));
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		rd(PMC_ADDR_PORT_A, 8'h00);
		rd(PMC_ADDR_PORT_B, 8'h00);
		for (int i = 0; i < 8; i++) begin
			cfg = 8'($urandom);
			wr(PMC_ADDR_PORT_A + 8'(i[0]), cfg);
			wr(8'h20 + 8'(cfg[3:0]), 8'hFF);
			rd(PMC_ADDR_PORT_A + 8'(i[0]), cfg & PMC_CTRL_MASK);
			rd(8'h20 + 8'(cfg[3:0]), 8'h00);
		end
		// Every rate, phase and select code on both ports
		for (int c = 0; c < 16; c++) begin
			cfg = {2'(c % 3 + 1), 3'h0, 3'(c)};
			// Complementary mics, so a swapped channel always shows
			n = int'($urandom);
			rise_bit <= 2'(n);
			fall_bit <= ~2'(n);
			wr(c[3] ? PMC_ADDR_PORT_A : PMC_ADDR_PORT_B, 8'h00);
			wr(c[3] ? PMC_ADDR_PORT_B : PMC_ADDR_PORT_A, cfg);
			smp_ready <= 1'b1;
			repeat (40) @(posedge clk);
			count_rises(c[3], n);
			check(8'(n), c[2] ? 8'h04 : 8'h08);
			got = 0;
			for (int k = 0; k < 200; k++) begin
				@(negedge clk);
				if (smp_valid === 1'b1 && smp_ready === 1'b1) begin
					got++;
					check({7'h00, cfg[6 + smp_data[2]]}, 8'h01);
					check({3'h0, smp_data}, {4'h0, c[3], smp_data[2], 1'b0,
						exp_bit(cfg, smp_data[2], c[3])});
				end
				@(posedge clk);
				smp_ready <= 1'($urandom);
			end
			check({7'h00, got > 8}, 8'h01);
		end
		// Stall the sink until the buffer refuses, then drain
		@(posedge clk);
		smp_ready <= 1'b0;
		repeat (300) @(posedge clk);
		smp_ready <= 1'b1;
		n = 0;
		@(negedge clk);
		while (smp_valid === 1'b1 && n < 60) begin
			n++;
			@(negedge clk);
		end
		check({7'h00, n >= 16 && n <= 26}, 8'h01);
		wr(PMC_ADDR_PORT_B, 8'h00);
		repeat (20) @(posedge clk);
		check({6'h00, mic_bit_clock}, 8'h00);
		tally_and_finish();
	end
endmodule : pmc_mic_ctrl_bench
`default_nettype wire
